// File: ulmc_pkg.sv
// Shared constants and types of the UART line and mode control block
package ulmc_pkg;
    localparam logic [3:0] OFFS_MODE         = 4'ha;
    localparam logic [3:0] OFFS_LINE         = 4'hb;
    localparam logic [7:0] RESET_MODE        = 8'h00;
    localparam logic [7:0] RESET_LINE        = 8'h05;
    localparam int         BIT_ECHO          = 7;
    localparam int         BIT_MULTIDROP     = 6;
    localparam int         BIT_LOOPBACK      = 5;
    localparam int         BIT_MATCH         = 4;
    localparam int         BIT_EMPTY_POL     = 3;
    localparam int         BIT_TRIG_POL      = 2;
    localparam int         BIT_QCLEAR        = 1;
    localparam int         BIT_SWRESET       = 0;
    localparam int         BIT_RTS           = 7;
    localparam int         BIT_BREAK         = 6;
    localparam int         BIT_FIXED_PAR     = 5;
    localparam int         BIT_EVEN          = 4;
    localparam int         BIT_PAR_EN        = 3;
    localparam int         BIT_STOP          = 2;
    localparam int         HOLD_LSB          = 0;
    localparam int         TRIG_LSB          = 4;
    localparam int         SEL_LSB           = 4;
    localparam int         BIT_SOFT_FLOW     = 3;
    localparam int         BIT_GPIO_QUAL     = 2;
    localparam logic [5:0] TICKS_BIT         = 6'h10;
    localparam logic [5:0] TICKS_HALF        = 6'h08;
    localparam logic [5:0] TICKS_STOP_ONE    = 6'h10;
    localparam logic [5:0] TICKS_STOP_ONEHALF = 6'h18;
    localparam logic [5:0] TICKS_STOP_TWO    = 6'h20;
    localparam logic [7:0] TRIG_STEP         = 8'h08;

    typedef struct packed {
        logic       request_to_send_level;
        logic       line_break_force;
        logic       fixed_parity_enable;
        logic       even_odd_select;
        logic       parity_bit_enable;
        logic       stop_length_select;
        logic       word_size_msb;
        logic       word_size_lsb;
    } ulmc_line_type;

    typedef struct packed {
        logic       ninth;
        logic [7:0] data;
    } ulmc_word_type;

    typedef enum logic [2:0] {
        ULMC_IDLE   = 3'b000,
        ULMC_START  = 3'b001,
        ULMC_DATA   = 3'b011,
        ULMC_PARITY = 3'b010,
        ULMC_STOP   = 3'b110
    } ulmc_state_type;
endpackage

// File: ulmc_top.sv
// UART line format and operating mode control with its data FIFOs
// Notes on behaviour
// - Echo blocking discards characters received while the transmitter is busy.
// - Echo blocking continues for the hold nibble interval after transmission ends.
// - Multidrop sends and receives an address flag in place of parity.
// - In multidrop the parity error flag shows the received ninth bit.
// - Loopback feeds TX to RX and RTS to CTS; TX pin floats.
// - In loopback the RTS pin still follows the software RTS bit.
// - Match detection compares against up to four selected characters, optionally gpio-qualified.
// - A matched character still enters the receive FIFO and raises an event.
// - With soft flow on, only the second resume and pause characters match.
// - Empty event polarity picks becoming empty or data entering an empty FIFO.
// - Level event polarity picks rising above or draining below the trigger.
// - Queue clear empties both FIFOs until software clears the bit.
// - Software reset restores register values and clears FIFOs; register port stays live.
// - Software RTS bit drives the RTS pin unless clock-on-RTS is selected.
// - Break bit holds TX low until software clears it.
// - Forced parity sends high for odd select and low for even select.
// - Parity off sends none; parity on generates and checks even or odd.
// - One stop bit, or 1.5 for 5-bit words and 2 otherwise.
// - With 5-bit words and long stop, any stop beyond one bit is valid.
// - Word size codes 0 to 3 select 5 to 8 data bits.
// - Echo hold delay is the nibble value in bit intervals, at most fifteen.
// - Receive trigger level is eight times the trigger field.
`timescale 1ns/1ps

module ulmc_fifo #(
    parameter int WIDTH = 9,
    parameter int DEPTH = 8
) (
    input  wire logic                       sys_clk,   // System clock
    input  wire logic                       sys_rst,   // Synchronous reset
    input  wire logic                       flush,     // Empty the FIFO
    input  wire logic [WIDTH-1:0]           in_data,   // Write data
    input  wire logic                       in_valid,  // Write request
    output logic                            in_ready,  // Space available
    output logic [WIDTH-1:0]                out_data,  // Head word
    output logic                            out_valid, // Head word present
    input  wire logic                       out_ready, // Consumer takes head
    output logic [$clog2(DEPTH+1)-1:0]      fill       // Words held
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] store [DEPTH];
    logic [AW-1:0]    wr_ptr;
    logic [AW-1:0]    rd_ptr;
    logic             do_push;
    logic             do_pop;

    assign in_ready  = fill != DEPTH[$clog2(DEPTH+1)-1:0];
    assign out_valid = fill != '0;
    assign do_push   = in_valid && in_ready && !flush;
    assign do_pop    = out_valid && out_ready && !flush;
    assign out_data  = store[rd_ptr];

    always_ff @(posedge sys_clk)
    begin
        if (do_push)
            store[wr_ptr] <= in_data;
    end

    always_ff @(posedge sys_clk)
    begin
        if (sys_rst || flush)
        begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            fill   <= '0;
        end
        else
        begin
            if (do_push)
                wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
            if (do_pop)
                rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
            if (do_push && !do_pop)
                fill <= fill + 1'b1;
            else if (do_pop && !do_push)
                fill <= fill - 1'b1;
        end
    end
endmodule // ulmc_fifo

module ulmc_top #(
    parameter int DEPTH = 8
) (
    input  wire logic                   sys_clk,         // 200 MHz system clock
    input  wire logic                   sys_rst,         // Synchronous reset, active high
    input  wire logic                   baud16_tick,     // Pulse at sixteen times the baud rate
    input  wire logic [3:0]             reg_addr,        // Register address
    input  wire logic                   reg_wr,          // Register write strobe
    input  wire logic                   reg_rd,          // Register read strobe
    input  wire logic [7:0]             reg_wdata,       // Register write data
    output logic [7:0]                  reg_rdata,       // Register read data
    input  wire logic [7:0]             half_duplex_timing, // Setup and hold nibbles
    input  wire logic [7:0]             flow_control_register, // Flow control settings
    input  wire logic [7:0]             queue_trigger_levels,  // Trigger nibbles
    input  wire logic                   clock_on_rts_pin,      // Route clock to RTS
    input  wire logic [7:0]             resume_char_one, // Match character
    input  wire logic [7:0]             resume_char_two, // Match character
    input  wire logic [7:0]             pause_char_one,  // Match character
    input  wire logic [7:0]             pause_char_two,  // Match character
    input  ulmc_pkg::ulmc_word_type     tx_word,         // Word to send, ninth = address flag
    input  wire logic                   tx_valid,        // Word offered
    output logic                        tx_ready,        // Transmit FIFO space
    output ulmc_pkg::ulmc_word_type     rx_word,         // Received word, ninth = flag
    output logic                        rx_valid,        // Received word present
    input  wire logic                   rx_ready,        // Host takes word
    input  wire logic                   rx_pin,          // Serial input pin
    input  wire logic                   cts_n_pin,       // Clear to send pin, active low
    input  wire logic [3:0]             gpio_pin,        // General purpose inputs
    output logic                        tx_pin_out,      // Serial output level
    output logic                        tx_pin_oe,       // Serial output enable
    output logic                        rts_n_pin,       // Request to send pin level
    output logic                        cts_level,       // Effective clear to send level
    output logic                        parity_error,    // Line status parity or ninth bit
    output logic                        framing_error,   // Line status stop bit missing
    output logic                        match_irq,       // Special character event pulse
    output logic                        rx_empty_irq,    // Receive empty event pulse
    output logic                        rx_level_irq     // Receive trigger event pulse
);
    import ulmc_pkg::*;
    localparam int CW = $clog2(DEPTH + 1);

    logic [7:0]     operating_mode_control;
    ulmc_line_type  line_cfg;
    logic           soft_reset;
    logic           flush;
    logic [5:0]     sync1;
    logic [5:0]     sync2;
    logic [5:0]     sync3;
    logic [5:0]     pins;
    ulmc_state_type tx_state;
    ulmc_state_type rx_state;
    ulmc_word_type  tx_head;
    ulmc_word_type  rx_shift;
    logic           tx_head_valid;
    logic           tx_pop;
    logic           tx_line;
    logic [5:0]     tx_ticks;
    logic [2:0]     tx_count;
    logic [7:0]     tx_data;
    logic           tx_extra;
    logic           tx_busy;
    logic [7:0]     hold_ticks;
    logic           echo_block;
    logic [3:0]     rx_ticks;
    logic [2:0]     rx_count;
    logic           rx_discard;
    logic           rx_line;
    logic           rx_push;
    logic [CW-1:0]  rx_fill;
    logic [CW-1:0]  rx_fill_prev;
    logic [7:0]     trig_level;
    logic           match_hit;
    logic           has_extra;

    function automatic logic [2:0] last_bit(input ulmc_line_type c);
        last_bit = {1'b1, c.word_size_msb, c.word_size_lsb};
    endfunction

    function automatic logic calc_parity(input logic [7:0] d, input ulmc_line_type c);
        logic [7:0] mask;
        mask = 8'hff >> (3'h3 - {1'b0, c.word_size_msb, c.word_size_lsb});
        calc_parity = ^(d & mask) ^ !c.even_odd_select;
    endfunction

    assign soft_reset = operating_mode_control[BIT_SWRESET];
    assign flush      = soft_reset || operating_mode_control[BIT_QCLEAR];
    assign has_extra  = line_cfg.parity_bit_enable || operating_mode_control[BIT_MULTIDROP];

    // Registers; the port keeps answering while the reset bit holds the rest
    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
        begin
            operating_mode_control <= RESET_MODE;
            line_cfg               <= RESET_LINE;
        end
        else
        begin
            // Reset takes effect at the write itself, so a read right after sees it
            if (reg_wr && reg_addr == OFFS_MODE && !reg_wdata[BIT_SWRESET])
                operating_mode_control <= reg_wdata;
            else if (soft_reset || (reg_wr && reg_addr == OFFS_MODE))
                operating_mode_control <= RESET_MODE | 8'h01;
            if (reg_wr && reg_addr == OFFS_LINE && !soft_reset)
                line_cfg <= reg_wdata;
            else if (soft_reset || (reg_wr && reg_addr == OFFS_MODE && reg_wdata[BIT_SWRESET]))
                line_cfg <= RESET_LINE;
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
            reg_rdata <= 8'h00;
        else if (reg_rd)
            unique case (reg_addr)
                OFFS_MODE: reg_rdata <= operating_mode_control;
                OFFS_LINE: reg_rdata <= line_cfg;
                default:   reg_rdata <= 8'h00;
            endcase
    end

    // Pins settle once the last two stages agree
    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
        begin
            sync1 <= 6'h3f;
            sync2 <= 6'h3f;
            sync3 <= 6'h3f;
            pins  <= 6'h3f;
        end
        else
        begin
            sync1 <= {gpio_pin, cts_n_pin, rx_pin};
            sync2 <= sync1;
            sync3 <= sync2;
            for (int i = 0; i < 6; i++)
                if (sync2[i] == sync3[i])
                    pins[i] <= sync3[i];
        end
    end

    assign tx_pin_out = tx_line && !line_cfg.line_break_force;
    assign tx_pin_oe  = !operating_mode_control[BIT_LOOPBACK];
    assign rts_n_pin  = clock_on_rts_pin ? baud16_tick
                                         : line_cfg.request_to_send_level;
    assign cts_level  = operating_mode_control[BIT_LOOPBACK]
                      ? line_cfg.request_to_send_level : pins[1];
    assign rx_line    = operating_mode_control[BIT_LOOPBACK] ? tx_pin_out : pins[0];

    ulmc_fifo #(
        .WIDTH (9),
        .DEPTH (DEPTH)
    ) tx_fifo (
        .sys_clk   (sys_clk),
        .sys_rst   (sys_rst),
        .flush     (flush),
        .in_data   (tx_word),
        .in_valid  (tx_valid),
        .in_ready  (tx_ready),
        .out_data  (tx_head),
        .out_valid (tx_head_valid),
        .out_ready (tx_pop),
        .fill      ()
    );

    // A head being flushed must not start a frame
    assign tx_pop  = tx_state == ULMC_IDLE && tx_head_valid && !flush;
    assign tx_busy = tx_state != ULMC_IDLE;

    // Transmitter; a frame in flight finishes on a queue clear but is abandoned on a software reset
    always_ff @(posedge sys_clk)
    begin
        if (sys_rst || soft_reset)
        begin
            tx_state <= ULMC_IDLE;
            tx_line  <= 1'b1;
            tx_ticks <= 6'h00;
            tx_count <= 3'h0;
            tx_data  <= 8'h00;
            tx_extra <= 1'b0;
        end
        else if (tx_pop)
        begin
            tx_state <= ULMC_START;
            tx_line  <= 1'b0;
            tx_ticks <= 6'h00;
            tx_data  <= tx_head.data;
            if (operating_mode_control[BIT_MULTIDROP])
                tx_extra <= tx_head.ninth;
            else if (line_cfg.fixed_parity_enable)
                tx_extra <= !line_cfg.even_odd_select;
            else
                tx_extra <= calc_parity(tx_head.data, line_cfg);
        end
        else if (baud16_tick && tx_busy)
        begin
            tx_ticks <= tx_ticks + 6'h01;
            unique case (tx_state)
                ULMC_START:
                    if (tx_ticks == TICKS_BIT - 6'h01)
                    begin
                        tx_state <= ULMC_DATA;
                        tx_line  <= tx_data[0];
                        tx_count <= 3'h0;
                        tx_ticks <= 6'h00;
                    end
                ULMC_DATA:
                    if (tx_ticks == TICKS_BIT - 6'h01)
                    begin
                        tx_ticks <= 6'h00;
                        tx_count <= tx_count + 3'h1;
                        if (tx_count != last_bit(line_cfg))
                            tx_line <= tx_data[tx_count + 3'h1];
                        else if (has_extra)
                        begin
                            tx_state <= ULMC_PARITY;
                            tx_line  <= tx_extra;
                        end
                        else
                        begin
                            tx_state <= ULMC_STOP;
                            tx_line  <= 1'b1;
                        end
                    end
                ULMC_PARITY:
                    if (tx_ticks == TICKS_BIT - 6'h01)
                    begin
                        tx_state <= ULMC_STOP;
                        tx_line  <= 1'b1;
                        tx_ticks <= 6'h00;
                    end
                ULMC_STOP:
                    if (tx_ticks == (!line_cfg.stop_length_select ? TICKS_STOP_ONE
                                   : last_bit(line_cfg) == 3'h4 ? TICKS_STOP_ONEHALF
                                   : TICKS_STOP_TWO) - 6'h01)
                        tx_state <= ULMC_IDLE;
                default:
                    tx_state <= ULMC_IDLE;
            endcase
        end
    end

    // Echo hold runs in sixteenth bits so the count is exact per bit
    always_ff @(posedge sys_clk)
    begin
        if (sys_rst || soft_reset)
            hold_ticks <= 8'h00;
        else if (tx_busy)
            hold_ticks <= {half_duplex_timing[HOLD_LSB +: 4], 4'h0};
        else if (baud16_tick && hold_ticks != 8'h00)
            hold_ticks <= hold_ticks - 8'h01;
    end

    assign echo_block = operating_mode_control[BIT_ECHO]
                      && (tx_busy || hold_ticks != 8'h00);

    // Receiver samples mid-bit on the sixteen-times tick
    always_ff @(posedge sys_clk)
    begin
        if (sys_rst || soft_reset)
        begin
            rx_state      <= ULMC_IDLE;
            rx_ticks      <= 4'h0;
            rx_count      <= 3'h0;
            rx_shift      <= '0;
            rx_discard    <= 1'b0;
            rx_push       <= 1'b0;
            parity_error  <= 1'b0;
            framing_error <= 1'b0;
        end
        else
        begin
            rx_push <= 1'b0;
            if (rx_state != ULMC_IDLE && echo_block)
                rx_discard <= 1'b1;
            if (rx_state == ULMC_IDLE)
            begin
                if (!rx_line)
                begin
                    rx_state   <= ULMC_START;
                    rx_ticks   <= 4'h0;
                    rx_discard <= echo_block;
                    rx_shift   <= '0;
                end
            end
            else if (baud16_tick)
            begin
                rx_ticks <= rx_ticks + 4'h1;
                unique case (rx_state)
                    ULMC_START:
                        if (rx_ticks == 4'(TICKS_HALF - 6'h01))
                        begin
                            rx_ticks <= 4'h0;
                            rx_count <= 3'h0;
                            rx_state <= rx_line ? ULMC_IDLE : ULMC_DATA;
                        end
                    ULMC_DATA:
                        if (rx_ticks == 4'hf)
                        begin
                            rx_shift.data[rx_count] <= rx_line;
                            rx_count <= rx_count + 3'h1;
                            if (rx_count == last_bit(line_cfg))
                                rx_state <= has_extra ? ULMC_PARITY : ULMC_STOP;
                        end
                    ULMC_PARITY:
                        if (rx_ticks == 4'hf)
                        begin
                            rx_shift.ninth <= rx_line;
                            rx_state       <= ULMC_STOP;
                        end
                    ULMC_STOP:
                        if (rx_ticks == 4'hf)
                        begin
                            // First stop bit alone decides, so any longer stop passes
                            framing_error <= !rx_line;
                            if (operating_mode_control[BIT_MULTIDROP])
                                parity_error <= rx_shift.ninth;
                            else
                                parity_error <= line_cfg.parity_bit_enable
                                    && rx_shift.ninth != calc_parity(rx_shift.data, line_cfg);
                            rx_push  <= !rx_discard && !echo_block;
                            rx_state <= ULMC_IDLE;
                        end
                    default:
                        rx_state <= ULMC_IDLE;
                endcase
            end
        end
    end

    always_comb
    begin
        match_hit = 1'b0;
        if (flow_control_register[SEL_LSB] && !flow_control_register[BIT_SOFT_FLOW])
            match_hit = match_hit
                || (rx_shift.data == resume_char_one
                    && (!flow_control_register[BIT_GPIO_QUAL] || pins[2]))
                || (rx_shift.data == pause_char_one
                    && (!flow_control_register[BIT_GPIO_QUAL] || pins[3]));
        if (flow_control_register[SEL_LSB + 1])
            match_hit = match_hit
                || (rx_shift.data == resume_char_two
                    && (!flow_control_register[BIT_GPIO_QUAL] || pins[4]))
                || (rx_shift.data == pause_char_two
                    && (!flow_control_register[BIT_GPIO_QUAL] || pins[5]));
    end

    // Matched characters are queued like any other
    always_ff @(posedge sys_clk)
    begin
        if (sys_rst || soft_reset)
            match_irq <= 1'b0;
        else
            match_irq <= rx_push && operating_mode_control[BIT_MATCH] && match_hit;
    end

    ulmc_fifo #(
        .WIDTH (9),
        .DEPTH (DEPTH)
    ) rx_fifo (
        .sys_clk   (sys_clk),
        .sys_rst   (sys_rst),
        .flush     (flush),
        .in_data   (rx_shift),
        .in_valid  (rx_push),
        .in_ready  (),
        .out_data  (rx_word),
        .out_valid (rx_valid),
        .out_ready (rx_ready),
        .fill      (rx_fill)
    );

    assign trig_level = TRIG_STEP * {4'h0, queue_trigger_levels[TRIG_LSB +: 4]};

    // Events come from the fill edge, so a full FIFO simply drops the word
    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
        begin
            rx_fill_prev <= '0;
            rx_empty_irq <= 1'b0;
            rx_level_irq <= 1'b0;
        end
        else
        begin
            rx_fill_prev <= rx_fill;
            if (operating_mode_control[BIT_EMPTY_POL])
                rx_empty_irq <= rx_fill_prev == '0 && rx_fill != '0;
            else
                rx_empty_irq <= rx_fill_prev != '0 && rx_fill == '0;
            if (operating_mode_control[BIT_TRIG_POL])
                rx_level_irq <= 8'(rx_fill_prev) >= trig_level
                             && 8'(rx_fill) < trig_level;
            else
                rx_level_irq <= 8'(rx_fill_prev) <= trig_level
                             && 8'(rx_fill) > trig_level;
        end
    end
endmodule // ulmc_top

// File: ulmc_monitor.sv
// Port checker of the line and mode control block
`timescale 1ns/1ps
module ulmc_monitor (
    input wire logic       sys_clk, sys_rst, baud16_tick, reg_wr, reg_rd, // Clock, strobes
    input wire logic [3:0] reg_addr,                                     // Address
    input wire logic [7:0] reg_wdata, reg_rdata,                         // Data
    input wire logic       clock_on_rts_pin, rx_valid, tx_pin_out, tx_pin_oe, // Levels
    input wire logic       rts_n_pin, cts_level, match_irq               // Outputs
);
    logic [4:0] s; // Shadow: reset, loopback, clear, RTS, break
    default clocking @(posedge sys_clk); endclocking
    default disable iff (sys_rst);
    always_ff @(posedge sys_clk)
        if (sys_rst || (reg_wr && reg_addr == 4'ha && reg_wdata[0])) s <= {!sys_rst, 4'h0};
        else if (reg_wr && reg_addr == 4'ha) s <= {1'h0, reg_wdata[5], reg_wdata[1], s[1:0]};
        else if (reg_wr && reg_addr == 4'hb && !s[4]) s[1:0] <= reg_wdata[7:6];
    sequence line_rd;
        reg_rd && reg_addr == 4'hb && s[4];
    endsequence
    rts_clk_a: assert property (clock_on_rts_pin |-> rts_n_pin == baud16_tick)
        else $error("rts clock");
    rts_bit_a: assert property (!clock_on_rts_pin |-> rts_n_pin == s[1]) else $error("rts");
    brk_low_a: assert property (s[0] |-> !tx_pin_out) else $error("break");
    loop_oe_a: assert property (tx_pin_oe == !s[3]) else $error("oe");
    loop_cts_a: assert property (s[3] && $past(s[3]) |-> cts_level == s[1])
        else $error("cts");
    swrst_rd_a: assert property (line_rd |=> reg_rdata == 8'h05) else $error("reset");
    qclr_rx_a: assert property (s[2] && $past(s[2]) |-> !rx_valid) else $error("clear");
    match_rx_a: assert property (match_irq |-> rx_valid) else $error("match");
endmodule // ulmc_monitor
bind ulmc_top ulmc_monitor u_ulmc_monitor (.*);

// File: ulmc_remote.sv
// Remote station model sampling the block's serial output
`timescale 1ns/1ps
module ulmc_remote (
    input wire logic sys_clk,     // System clock
    input wire logic baud16_tick, // Sixteen ticks a bit
    input wire logic tx_pin_out   // Line from the block
);
    task automatic tk(input int k);
        repeat (k) @(posedge sys_clk iff baud16_tick);
    endtask
    task automatic recv(output logic [8:0] w, input int n);
        w = 9'h000;
        @(negedge tx_pin_out);
        tk(8);
        for (int i = 0; i < n; i++)
        begin
            tk(16);
            w[i] = tx_pin_out;
        end
    endtask
endmodule // ulmc_remote

// File: uart_line_mode_control_bench.sv
// Self-checking bench of the line and mode control block
`timescale 1ns/1ps
module uart_line_mode_control_bench;
    import ulmc_pkg::*;
    logic sys_clk = 1'h0, sys_rst = 1'h1, baud16_tick = 1'h0, reg_wr = 1'h0, reg_rd = 1'h0;
    logic clock_on_rts_pin = 1'h0, tx_valid = 1'h0, rx_ready = 1'h0, cts_n_pin = 1'h0;
    logic rx_pin = 1'h1, tx_ready, rx_valid, tx_pin_out, tx_pin_oe, rts_n_pin, cts_level;
    logic parity_error, framing_error, match_irq, rx_empty_irq, rx_level_irq;
    logic [3:0] reg_addr = 4'h0, gpio_pin = 4'h0;
    logic [7:0] reg_wdata = 8'h00, reg_rdata, half_duplex_timing = 8'h00, pause_char_one = 8'h00;
    logic [7:0] queue_trigger_levels = 8'h00, flow_control_register = 8'h10;
    logic [7:0] resume_char_one = 8'h5b, resume_char_two = 8'h00, pause_char_two = 8'h00;
    ulmc_word_type tx_word = 9'h000, rx_word;
    logic [8:0] got;
    int err_count = 0, cmp_count = 0, cyc = 0;
    ulmc_top u_ulmc_top (.*);
    ulmc_remote u_ulmc_remote (.*);
    always #2.5 sys_clk = ~sys_clk;
    always @(negedge sys_clk)
    begin
        cyc <= cyc + 1;
        baud16_tick <= cyc % 4 == 0;
        if (cyc == 20000) end_of_test(1);
    end
    task automatic chk(input logic [9:0] s, e);
        cmp_count++;
        err_count += int'(s !== e);
        if (s !== e) $display("BAD %0t %h %h", $time, s, e);
    endtask
    task automatic end_of_test(input int bad);
        err_count += bad;
        if (err_count == 0 && cmp_count > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    task automatic rg(input logic w, input logic [3:0] a, input logic [7:0] d);
        {reg_wr, reg_rd, reg_addr, reg_wdata} = {w, !w, a, d};
        @(negedge sys_clk);
        {reg_wr, reg_rd} = 2'h0;
        @(negedge sys_clk);
    endtask
    task automatic push(input logic [8:0] w);
        {tx_valid, tx_word} = {1'h1, w};
        @(negedge sys_clk);
        tx_valid = 1'h0;
    endtask
    task automatic t_tx; // Parity kinds, word size and multidrop on the wire
        logic [7:0] lc [4] = '{8'h1b, 8'h2b, 8'h08, 8'h1b};
        logic [8:0] ex [4] = '{9'h15b, 9'h15b, 9'h03b, 9'h05b};
        for (int i = 0; i < 4; i++)
        begin
            clock_on_rts_pin = i[0];
            rg(1'h1, 4'ha, i == 3 ? 8'h40 : 8'h00);
            rg(1'h1, 4'hb, lc[i]);
            fork
                u_ulmc_remote.recv(got, i == 2 ? 6 : 9);
                push(9'h05b);
            join
            chk(got, ex[i]);
            u_ulmc_remote.tk(48);
            @(negedge sys_clk);
        end
    endtask
    task automatic t_mode; // Break, looped match, queue clear, software reset
        rg(1'h1, 4'hb, 8'hc3);
        chk(tx_pin_out, 1'h0);
        rg(1'h1, 4'hb, 8'h83);
        rg(1'h1, 4'ha, 8'h70);
        chk({tx_pin_oe, cts_level}, 2'h1);
        push(9'h15b);
        for (int k = 0; k < 3000 && match_irq !== 1'h1; k++) @(negedge sys_clk);
        chk({match_irq, rx_word}, 10'h35b);
        chk({parity_error, framing_error, tx_ready}, 3'h5);
        @(negedge sys_clk);
        chk(rx_level_irq, 1'h1);
        rg(1'h1, 4'ha, 8'h02);
        chk(rx_valid, 1'h0);
        @(negedge sys_clk);
        chk(rx_empty_irq, 1'h1);
        rg(1'h1, 4'ha, 8'h01);
        rg(1'h0, 4'hb, 8'h00);
        chk(reg_rdata, RESET_LINE);
        rg(1'h1, 4'ha, 8'h00);
        rg(1'h0, 4'h3, 8'h00);
        chk(reg_rdata, 8'h00);
    endtask
    initial
    begin
        repeat (4) @(negedge sys_clk);
        sys_rst = 1'h0;
        t_tx;
        t_mode;
        end_of_test(0);
    end
endmodule // uart_line_mode_control_bench
